//--- core/psc_consts.vh
// Constants for the peripheral set/clear register bank
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
// Peripheral region: uppermost 3 Mbyte of the 32-bit space
`define PSC_REGION_BASE   32'hFFD0_0000
`define PSC_WIN_BITS      14
`define PSC_AIC_WIN_BITS  12
// Window index width and index of the first window in the region
`define PSC_IDX_BITS      8
`define PSC_REGION_IDX    8'h40
// Address tag of the interrupt controller window
`define PSC_AIC_TAG       20'hF_FFFF
// Registers live in the first 4 Kbyte quarter of a window
`define PSC_SUB_ZERO      2'h0
// Interrupt controller window base (last 4 Kbyte)
`define PSC_AIC_BASE      32'hFFFF_F000
// Offsets inside a window of one triple-mapped register
`define PSC_OFF_SET       12'h000
`define PSC_OFF_CLR       12'h004
`define PSC_OFF_STAT      12'h008
`define PSC_RESET_VAL     32'h0000_0000
`define PSC_ZERO          32'h0000_0000
`endif

//--- core/psc_regs.v
// Peripheral address decoder with triple-mapped set/clear/status registers
`timescale 1ns/100ps
`default_nettype none
`include "psc_consts.vh"
module psc_regs #(
	parameter NPER = 4
)(
	// Clock and reset
	input  wire                clk_i,
	input  wire                nrst_i,
	// Peripheral bus slave
	input  wire                psel_i,
	input  wire                penable_i,
	input  wire                pwrite_i,
	input  wire [31:0]         paddr_i,
	input  wire [31:0]         pwdata_i,
	output reg  [31:0]         prdata_o,
	output wire                pready_o,
	output wire                pslverr_o,
	// Register contents and window selects
	output wire [32*NPER-1:0]  reg_val_o,
	output wire [NPER-1:0]     per_sel_o,
	output wire                aic_sel_o
);
	// Width of the window index inside the peripheral region
	localparam IDXW = `PSC_IDX_BITS;

	// Address decode
	wire               in_region;
	wire               aic_hit;
	wire [IDXW-1:0]    win_tag;
	wire [IDXW-1:0]    win_idx;
	wire [11:0]        off;
	wire               sub_zero;
	wire               per_hit;

	// Bus phases
	wire               setup_ph;
	wire               access_ph;
	wire               wr_acc;
	wire               rd_setup;

	// Offset decode
	reg                off_set;
	reg                off_clr;
	reg                off_stat;

	// Per-window results
	wire [NPER-1:0]    win_match;
	wire [NPER-1:0]    rd_hit;
	wire [32*NPER-1:0] stat_flat;

	// Read path
	reg  [31:0]        rd_d;
	reg  [31:0]        prdata_q;
	integer            k;

	// Region check: everything at or above the region base
	assign in_region = (paddr_i >= `PSC_REGION_BASE);

	// The interrupt controller only claims its own 4 Kbyte
	assign aic_hit = (paddr_i[31:`PSC_AIC_WIN_BITS] == `PSC_AIC_TAG);

	// Window index counted up from the region base
	assign win_tag = paddr_i[`PSC_WIN_BITS+IDXW-1:`PSC_WIN_BITS];
	assign win_idx = win_tag - `PSC_REGION_IDX;

	// Offset counted up from the window base
	assign off      = paddr_i[11:0];
	assign sub_zero = (paddr_i[`PSC_WIN_BITS-1:`PSC_AIC_WIN_BITS] == `PSC_SUB_ZERO);
	assign per_hit  = in_region & ~aic_hit;

	// Setup and access phases of the peripheral bus
	assign setup_ph  = psel_i & ~penable_i;
	assign access_ph = psel_i & penable_i;
	assign wr_acc    = access_ph & pwrite_i;
	assign rd_setup  = setup_ph & ~pwrite_i;

	// No wait states; error only for addresses below the region
	assign pready_o  = 1'b1;
	assign pslverr_o = access_ph & ~in_region;
	assign aic_sel_o = psel_i & aic_hit;

	// Which of the three addresses of a register is reached
	always @*
	begin
		off_set  = 1'b0;
		off_clr  = 1'b0;
		off_stat = 1'b0;
		case (off)
			`PSC_OFF_SET:
			begin
				off_set = 1'b1;
			end
			`PSC_OFF_CLR:
			begin
				off_clr = 1'b1;
			end
			`PSC_OFF_STAT:
			begin
				off_stat = 1'b1;
			end
			default:
			begin
				off_set  = 1'b0;
				off_clr  = 1'b0;
				off_stat = 1'b0;
			end
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < NPER; g = g + 1)
		begin : g_per
			localparam [IDXW-1:0] WIN = g;
			reg  [31:0] val_q;
			reg  [31:0] val_d;
			wire        set_wr;
			wire        clr_wr;

			assign win_match[g] = per_hit & (win_idx == WIN);
			assign set_wr       = wr_acc & win_match[g] & sub_zero & off_set;
			assign clr_wr       = wr_acc & win_match[g] & sub_zero & off_clr;
			assign rd_hit[g]    = rd_setup & win_match[g] & sub_zero & off_stat;

			// Only the one-bits of the written word act
			always @*
			begin
				val_d = val_q;
				if (set_wr)
				begin
					val_d = val_q | pwdata_i;
				end
				else if (clr_wr)
				begin
					val_d = val_q & ~pwdata_i;
				end
			end

			always @(posedge clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					val_q <= `PSC_RESET_VAL;
				end
				else
				begin
					val_q <= val_d;
				end
			end

			assign per_sel_o[g] = psel_i & win_match[g];
			// Bit 0 of each register sits in byte lane 0, the lowest address
			assign stat_flat[32*g +: 32] = val_q;
		end
	endgenerate

	assign reg_val_o = stat_flat;

	// Read word chosen during setup; set and clear addresses read zero
	always @*
	begin
		rd_d = `PSC_ZERO;
		for (k = 0; k < NPER; k = k + 1)
		begin
			if (rd_hit[k])
			begin
				rd_d = stat_flat[32*k +: 32];
			end
		end
	end

	// Captured at the end of setup so it stands for the whole access
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			prdata_q <= `PSC_ZERO;
		end
		else if (setup_ph)
		begin
			prdata_q <= rd_d;
		end
	end

	always @*
	begin
		prdata_o = prdata_q;
	end
endmodule // psc_regs
`default_nettype wire

//--- verif/psc_regs_assertions.sv
// Checker for the set/clear bank
`timescale 1ns/100ps
`default_nettype none
module psc_regs_assertions #(parameter NPER=4)(input wire logic clk_i,nrst_i,psel_i,penable_i,pwrite_i,
	input wire logic aic_sel_o,pready_o,pslverr_o,input wire logic [31:0] paddr_i,pwdata_i,prdata_o,
	input wire logic [NPER-1:0] per_sel_o,input wire logic [32*NPER-1:0] reg_val_o);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
property p_rd0; psel_i&&penable_i&&!pwrite_i&&paddr_i==32'hFFD0_0000|->prdata_o==0; endproperty
a_rd0: assert property (p_rd0) else $error("set read not zero");
property p_aic; aic_sel_o==(psel_i&&paddr_i[31:12]==20'hF_FFFF); endproperty
a_aic: assert property (p_aic) else $error("bad 4K select");
property p_w0; per_sel_o[0]==(psel_i&&paddr_i[31:14]==18'h3_FF40); endproperty
a_w0: assert property (p_w0) else $error("bad window select");
property p_set; psel_i&&penable_i&&pwrite_i&&paddr_i==32'hFFD0_0000|=>
	reg_val_o[31:0]==($past(reg_val_o[31:0])|$past(pwdata_i)); endproperty
a_set: assert property (p_set) else $error("set write wrong");
property p_clr; psel_i&&penable_i&&pwrite_i&&paddr_i==32'hFFD0_0004|=>
	reg_val_o[31:0]==($past(reg_val_o[31:0])&~$past(pwdata_i)); endproperty
a_clr: assert property (p_clr) else $error("clear write wrong");
property p_keep; !(psel_i&&penable_i&&pwrite_i)|=>$stable(reg_val_o); endproperty
a_keep: assert property (p_keep) else $error("register changed without write");
property p_stat; psel_i&&penable_i&&!pwrite_i&&paddr_i==32'hFFD0_0008|->prdata_o==reg_val_o[31:0]; endproperty
a_stat: assert property (p_stat) else $error("status read wrong");
property p_err; pslverr_o==(psel_i&&penable_i&&paddr_i<32'hFFD0_0000); endproperty
a_err: assert property (p_err) else $error("bad error response");
property p_rdy; pready_o; endproperty
a_rdy: assert property (p_rdy) else $error("wait state inserted");
endmodule // psc_regs_assertions
`default_nettype wire

//--- verif/psc_apb_model.sv
// Bus master standing for the bridge
`timescale 1ns/100ps
`default_nettype none
module psc_apb_model(input wire logic clk_i,input wire logic [31:0] rd_i,output logic s,e,w,
	output logic [31:0] a,d);
logic [31:0] q;
initial {s,e,w,a,d}=0;
// Setup, access, then data taken at the ready edge
task xfer(input logic wr,input logic [31:0] ad,dt);
	@(posedge clk_i) {s,w,a,d}<={1'b1,wr,ad,dt};
	@(posedge clk_i) e<=1;
	@(posedge clk_i) q=rd_i;
	{s,e}<=0;
	d<=~dt;
endtask
endmodule // psc_apb_model
`default_nettype wire

//--- verif/psc_regs_tb_top.sv
// Testbench for the set/clear bank
`timescale 1ns/100ps
`default_nettype none
module psc_regs_tb_top;
logic clk_i=0,nrst_i=0,s,e,w;
logic [31:0] a,d,r;
int n_errors=0,num_checks=0,cyc=0;
psc_apb_model m(.clk_i(clk_i),.rd_i(r),.s(s),.e(e),.w(w),.a(a),.d(d));
psc_regs u_dut(.clk_i(clk_i),.nrst_i(nrst_i),.psel_i(s),.penable_i(e),.pwrite_i(w),.paddr_i(a),
	.pwdata_i(d),.prdata_o(r),.pready_o(),.pslverr_o(),.reg_val_o(),.per_sel_o(),.aic_sel_o());
initial forever #25 clk_i=~clk_i;
always @(posedge clk_i) if (++cyc>2000)
begin
	n_errors++;
	summarize();
end
task summarize;
	if (n_errors==0&&num_checks>0) $display("bench passed");
	else $display("bench failed");
	$finish;
endtask
task chk(input logic [31:0] x);
	num_checks++;
	if (m.q!==x)
	begin
		n_errors++;
		$display("ERROR %0t read %h expected %h",$time,m.q,x);
	end
endtask
task t_err;
	m.xfer(1,32'hFFFF_F000,32'hFFFF_FFFF);
	m.xfer(1,32'h0000_0000,32'hFFFF_FFFF);
	m.xfer(1,32'hFFD0_000C,32'hFFFF_FFFF);
	m.xfer(0,32'hFFD0_0008,0);
	chk(32'h0000_00E4);
endtask
task t_bits;
	m.xfer(1,32'hFFD0_0000,32'h0000_00F5);
	m.xfer(1,32'hFFD0_0004,32'h0000_0011);
	m.xfer(0,32'hFFD0_0008,0);
	chk(32'h0000_00E4);
endtask
task t_win;
	m.xfer(1,32'hFFD0_C000,32'h1234_5678);
	m.xfer(0,32'hFFD0_C008,0);
	chk(32'h1234_5678);
	m.xfer(0,32'hFFD0_0008,0);
	chk(32'h0000_00E4);
	m.xfer(0,32'hFFD0_C000,0);
	chk(0);
endtask
initial
begin
	repeat (10) @(posedge clk_i);
	nrst_i<=1;
	t_bits();
	t_win();
	t_err();
	summarize();
end
endmodule // psc_regs_tb_top
bind psc_regs psc_regs_assertions #(.NPER(NPER)) u_chk(.*);
`default_nettype wire
